/* include/prsr_map.svh */
`ifndef PRSR_MAP_SVH
`define PRSR_MAP_SVH

// start-up times and derived counts at 250 MHz
`define PRSR_CLK_MHZ 250
`define PRSR_CMD_READY_US 1000
`define PRSR_MEAS_READY_US 2500
`define PRSR_CMD_READY_CYC (`PRSR_CMD_READY_US * `PRSR_CLK_MHZ)
`define PRSR_MEAS_READY_CYC (`PRSR_MEAS_READY_US * `PRSR_CLK_MHZ)
// default 7-bit target address
`define PRSR_ADDR_DEFAULT 7'h18
// status byte bit positions
`define PRSR_ST_POWERED 6
`define PRSR_ST_BUSY 5
`define PRSR_ST_MEMERR 2
`define PRSR_ST_SAT 0
// measurement command bytes
`define PRSR_CMD_MEAS 8'haa
`define PRSR_CMD_ARG 8'h00
// number of bytes in one readout
`define PRSR_READ_BYTES 4
// fifo shape
`define PRSR_FIFO_W 8
`define PRSR_FIFO_D 8

`endif

/* include/prsr_pkg.sv */
package prsr_pkg;
  // one sampled result as taken from the conversion engine
  typedef struct packed {
    logic memerr;
    logic sat;
    logic [23:0] pressure;
  } prsr_result_t;

  // open-drain pin: drive low while oe is high
  typedef struct packed {
    logic o;
    logic oe;
  } prsr_od_t;

  typedef enum logic [3:0] {
    PRSR_IDLE, PRSR_ADDR, PRSR_ADDR_ACK, PRSR_TX, PRSR_TX_ACK,
    PRSR_RX, PRSR_RX_ACK, PRSR_IGNORE
  } prsr_bus_t;

  typedef enum logic [1:0] {
    PRSR_PWR_WAIT, PRSR_STANDBY, PRSR_CONVERT
  } prsr_pwr_t;
endpackage : prsr_pkg

/* core/prsr_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module prsr_fifo
  import prsr_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk, // core clock
  input wire logic rst, // sync reset, empties the queue; storage not cleared
  input wire logic [WIDTH-1:0] in_data, // write word
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  output logic [WIDTH-1:0] out_data, // head word
  output logic out_valid, // head word present
  input wire logic out_ready // head consumed
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // full and empty come from the occupancy count
  assign in_ready = (cnt_q != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : prsr_fifo
`default_nettype wire

/* core/prsr_readout.sv */
`timescale 1ns/100ps
`default_nettype none
`include "prsr_map.svh"
module prsr_readout
  import prsr_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = `PRSR_ADDR_DEFAULT,
  parameter int CMD_READY_CYC = `PRSR_CMD_READY_CYC,
  parameter int MEAS_READY_CYC = `PRSR_MEAS_READY_CYC
) (
  input wire logic ref_clk, // core clock, 250 MHz
  input wire logic rst, // sync reset, active high
  input wire logic sensor_reset_n, // reset pad, active low
  input wire logic scl_i, // shared clock pad level
  input wire logic sda_i, // shared data pad level
  output logic sda_oe, // pull data low while high
  output logic sda_o, // data pad drive value, always 0
  output logic scl_oe, // clock pad enable, always 0
  output logic eoc, // end of conversion
  output logic cmd_ready, // start-up done, commands accepted
  output logic meas_start, // pulse: conversion begins
  input wire logic meas_done, // pulse from conversion engine
  input wire logic [23:0] meas_pressure, // compensated result
  input wire logic meas_sat, // math saturation seen
  input wire logic memerr, // power-up checksum failed
  output logic [7:0] status // current status byte
);
  // *****************************************
  // pad synchronisers
  // *****************************************
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic [1:0] rstn_s_q;
  logic scl_d_q;
  logic sda_d_q;
  logic rstn_d_q;

  // two flops before any pad is read; keeps up with fast mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      rstn_s_q <= 2'h3;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
      rstn_d_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      rstn_s_q <= {rstn_s_q[0], sensor_reset_n};
      scl_d_q <= scl_s_q[1];
      sda_d_q <= sda_s_q[1];
      rstn_d_q <= rstn_s_q[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic pad_rst;
  assign scl_rise = scl_s_q[1] && !scl_d_q;
  assign scl_fall = !scl_s_q[1] && scl_d_q;
  assign bus_start = scl_s_q[1] && scl_d_q && sda_d_q && !sda_s_q[1];
  assign bus_stop = scl_s_q[1] && scl_d_q && !sda_d_q && sda_s_q[1];
  // low level on the pad holds the whole sensor in reset
  assign pad_rst = !rstn_s_q[1];
  logic srst;
  assign srst = rst || pad_rst;

  // *****************************************
  // power-up sequence and conversion control
  // *****************************************
  prsr_pwr_t pwr_q;
  logic [31:0] up_q;
  logic cmd_ok_q;
  logic meas_ok_q;
  logic go_q;
  logic sat_q;
  logic memerr_q;
  logic [23:0] press_q;

  // start-up counter restarts on every reset, pad or core
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      up_q <= '0;
      cmd_ok_q <= 1'b0;
      meas_ok_q <= 1'b0;
    end else begin
      if (!meas_ok_q) begin
        up_q <= up_q + 32'h1;
      end
      if (up_q == 32'(CMD_READY_CYC - 1)) begin
        cmd_ok_q <= 1'b1;
      end
      if (up_q == 32'(MEAS_READY_CYC - 1)) begin
        meas_ok_q <= 1'b1;
      end
    end
  end

  // checksum flag is captured once, after reset release
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      memerr_q <= 1'b0;
    end else if (up_q == 32'h0) begin
      memerr_q <= memerr;
    end
  end

  // standby, converting, back to standby on its own
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwr_q <= PRSR_PWR_WAIT;
      meas_start <= 1'b0;
      eoc <= 1'b0;
      sat_q <= 1'b0;
      press_q <= '0;
    end else begin
      meas_start <= 1'b0;
      case (pwr_q)
        PRSR_PWR_WAIT: begin
          if (meas_ok_q) begin
            pwr_q <= PRSR_STANDBY;
          end
        end
        PRSR_STANDBY: begin
          if (go_q) begin
            pwr_q <= PRSR_CONVERT;
            meas_start <= 1'b1;
            eoc <= 1'b0;
          end
        end
        PRSR_CONVERT: begin
          if (meas_done) begin
            pwr_q <= PRSR_STANDBY;
            press_q <= meas_pressure;
            sat_q <= meas_sat;
            eoc <= 1'b1;
          end
        end
        default: pwr_q <= PRSR_PWR_WAIT;
      endcase
    end
  end

  logic busy;
  assign busy = (pwr_q != PRSR_STANDBY);
  logic [7:0] status_d;
  // unlisted bits read zero
  always_comb begin
    status_d = 8'h00;
    status_d[`PRSR_ST_POWERED] = 1'b1;
    status_d[`PRSR_ST_BUSY] = busy;
    status_d[`PRSR_ST_MEMERR] = memerr_q;
    status_d[`PRSR_ST_SAT] = sat_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status <= 8'h00;
      cmd_ready <= 1'b0;
    end else begin
      status <= pad_rst ? 8'h00 : status_d;
      cmd_ready <= cmd_ok_q && !pad_rst;
    end
  end

  // *****************************************
  // i2c target engine
  // *****************************************
  prsr_bus_t bus_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic [1:0] byte_q;
  logic [1:0] cmd_q;
  logic rd_q;
  logic sda_oe_q;
  logic load;
  logic [7:0] fifo_out;
  logic fifo_valid;
  logic fifo_in_ready;
  logic fifo_pop;
  logic fifo_push;
  logic [7:0] fifo_in;

  // readout bytes queue: status then pressure msb first
  always_comb begin
    fifo_in = status_d;
    if (byte_q == 2'h1) begin
      fifo_in = press_q[23:16];
    end else if (byte_q == 2'h2) begin
      fifo_in = press_q[15:8];
    end else if (byte_q == 2'h3) begin
      fifo_in = press_q[7:0];
    end
  end

  // bytes are snapshotted into the fifo as the address is accepted
  logic [2:0] fill_q;
  assign fifo_push = (fill_q != 3'h0) && fifo_in_ready;
  assign load = (bus_q == PRSR_ADDR_ACK) && scl_fall;

  prsr_fifo #(
    .WIDTH(`PRSR_FIFO_W),
    .DEPTH(`PRSR_FIFO_D)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(srst || bus_start || bus_stop),
    .in_data(fifo_in),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );
  assign fifo_pop = load || ((bus_q == PRSR_TX_ACK) && scl_rise && !sda_d_q
    && fifo_valid);

  // bus state, one bit per scl clock; device only answers, never starts
  always_ff @(posedge ref_clk) begin
    if (srst || bus_stop) begin
      bus_q <= PRSR_IDLE;
      sda_oe_q <= 1'b0;
      bit_q <= '0;
      sh_q <= '0;
      rd_q <= 1'b0;
      byte_q <= '0;
      fill_q <= '0;
      cmd_q <= '0;
      go_q <= 1'b0;
    end else if (bus_start) begin
      bus_q <= PRSR_ADDR;
      sh_q <= '0; // a repeated start must not see stale bits
      sda_oe_q <= 1'b0;
      bit_q <= '0;
      go_q <= 1'b0;
      cmd_q <= '0;
    end else begin
      go_q <= 1'b0;
      if (fifo_push) begin
        fill_q <= fill_q - 3'h1;
        byte_q <= byte_q + 2'h1;
      end
      case (bus_q)
        PRSR_ADDR, PRSR_RX: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_d_q};
            bit_q <= bit_q + 3'h1;
          end
          if (scl_fall && bit_q == 3'h0 && bus_q == PRSR_ADDR
              && sh_q[7:1] != 7'h0) begin
            rd_q <= sh_q[0];
            if (sh_q[7:1] == TARGET_ADDR && (cmd_ok_q || sh_q[0])) begin
              bus_q <= PRSR_ADDR_ACK;
              sda_oe_q <= 1'b1;
              if (sh_q[0]) begin
                fill_q <= 3'(`PRSR_READ_BYTES);
                byte_q <= '0;
              end
            end else begin
              bus_q <= PRSR_IGNORE;
            end
          end else if (scl_fall && bit_q == 3'h0 && bus_q == PRSR_RX) begin
            bus_q <= PRSR_RX_ACK;
            sda_oe_q <= 1'b1;
            // aa 00 00 sequence; ignored while converting
            if (cmd_q == 2'h0 && sh_q == `PRSR_CMD_MEAS) begin
              cmd_q <= 2'h1;
            end else if (cmd_q != 2'h0 && sh_q == `PRSR_CMD_ARG) begin
              cmd_q <= cmd_q + 2'h1;
              go_q <= (cmd_q == 2'h2) && !busy && meas_ok_q;
            end else begin
              cmd_q <= 2'h0;
            end
          end
        end
        PRSR_ADDR_ACK, PRSR_RX_ACK: begin
          if (scl_fall) begin
            bit_q <= '0;
            sh_q <= '0;
            if (rd_q) begin
              bus_q <= PRSR_TX;
              sda_oe_q <= !fifo_out[7];
              sh_q <= {fifo_out[6:0], 1'b1};
              bit_q <= 3'h1;
            end else begin
              bus_q <= PRSR_RX;
              sda_oe_q <= 1'b0;
            end
          end
        end
        PRSR_TX: begin
          if (scl_fall) begin
            if (bit_q == 3'h0) begin
              bus_q <= PRSR_TX_ACK;
              sda_oe_q <= 1'b0;
            end else begin
              sda_oe_q <= !sh_q[7];
              sh_q <= {sh_q[6:0], 1'b1};
              bit_q <= bit_q + 3'h1;
            end
          end
        end
        PRSR_TX_ACK: begin
          // nack ends the read; past the fourth byte send ones
          if (scl_rise) begin
            bus_q <= sda_d_q ? PRSR_IGNORE : PRSR_TX_ACK;
            sh_q <= fifo_valid ? fifo_out : 8'hff;
          end
          if (scl_fall && bus_q == PRSR_TX_ACK) begin
            bus_q <= PRSR_TX;
            sda_oe_q <= !sh_q[7];
            sh_q <= {sh_q[6:0], 1'b1};
            bit_q <= 3'h1;
          end
        end
        default: sda_oe_q <= 1'b0;
      endcase
    end
  end

  // open-drain only: data released or pulled low, clock never driven
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      sda_oe <= sda_oe_q && !pad_rst;
      sda_o <= 1'b0;
      scl_oe <= 1'b0;
    end
  end
endmodule : prsr_readout
`default_nettype wire

/* test/prsr_readout_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// ***************************
// readout port checker
// ***************************
module prsr_readout_chk #(
  parameter int CMD_READY_CYC = 20,
  parameter int MEAS_READY_CYC = 50
) (
  input wire logic ref_clk, // core clock
  input wire logic rst, // sync reset
  input wire logic sensor_reset_n, // reset pad
  input wire logic scl_i, // clock pad level
  input wire logic sda_oe, // data pull
  input wire logic sda_o, // data drive value
  input wire logic scl_oe, // clock pad enable
  input wire logic eoc, // end of conversion
  input wire logic cmd_ready, // start-up done
  input wire logic meas_start, // start pulse
  input wire logic meas_done, // result strobe
  input wire logic [7:0] status // status byte
);
  int age_q;
  logic [1:0] pad_q;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  // pad seen through two flops, as the design sees it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pad_q <= 2'h3;
    end else begin
      pad_q <= {pad_q[0], sensor_reset_n};
    end
  end
  // age since any reset, aligned with the design's start-up count
  always_ff @(posedge ref_clk) begin
    if (rst || !pad_q[1]) begin
      age_q <= 0;
    end else if (age_q < MEAS_READY_CYC + 64) begin
      age_q <= age_q + 1;
    end
  end
  a_clk_pad_free: assert property (scl_oe == 1'b0)
    else $error("clock pad driven");
  a_sda_drain_only: assert property (sda_o == 1'b0)
    else $error("data pad driven high");
  a_sda_low_phase: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data pull moved while clock high");
  a_status_zeros: assert property (status[7] == 1'b0
    && status[4:3] == 2'b00 && status[1] == 1'b0)
    else $error("reserved status bit set");
  a_eoc_on_done: assert property (meas_done |-> ##[1:2] eoc)
    else $error("eoc missing after result");
  a_eoc_cleared: assert property (meas_start |-> ##[0:1] !eoc)
    else $error("eoc kept over new start");
  a_start_pulse: assert property (meas_start |=> !meas_start)
    else $error("start pulse too long");
  a_start_idle: assert property (meas_start |->
    !$past(status[5]) && cmd_ready)
    else $error("start while busy");
  a_ready_early: assert property (cmd_ready |-> age_q >= CMD_READY_CYC)
    else $error("commands open too early");
  a_ready_late: assert property (age_q == CMD_READY_CYC + 8 |-> cmd_ready)
    else $error("commands open too late");
  a_busy_startup: assert property (age_q < MEAS_READY_CYC
    && status[6] |-> status[5])
    else $error("ready before start-up time");
  a_pad_reset: assert property (!sensor_reset_n [*5] |->
    status == 8'h00 && !cmd_ready)
    else $error("pad reset ignored");
endmodule : prsr_readout_chk
bind prsr_readout prsr_readout_chk #(
  .CMD_READY_CYC(CMD_READY_CYC),
  .MEAS_READY_CYC(MEAS_READY_CYC)
) u_prsr_readout_chk (.ref_clk, .rst, .sensor_reset_n, .scl_i, .sda_oe,
  .sda_o, .scl_oe, .eoc, .cmd_ready, .meas_start, .meas_done, .status);
`default_nettype wire

/* test/prsr_i2c_mst.sv */
`timescale 1ns/100ps
`default_nettype none
// ***************************
// bus master model
// ***************************
module prsr_i2c_mst (
  output logic scl_m, // clock drive, 1 releases
  output logic sda_m, // data drive, 1 releases
  input wire logic sda_line // resolved data line
);
  int hp = 32; // half clock period in ns, raised for slow traffic
  // no select pad on this build; select is a spi master duty
  // both lines released at power-up
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // one bit: data set mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    #(hp / 2) sda_m = b;
    #(hp / 2) scl_m = 1'b1;
    #(hp / 2) r = sda_line;
    #(hp / 2) scl_m = 1'b0;
  endtask : bit_io
  task automatic start();
    #(hp / 2) sda_m = 1'b1;
    #(hp / 2) scl_m = 1'b1;
    #hp sda_m = 1'b0;
    #hp scl_m = 1'b0;
  endtask : start
  task automatic stop();
    #(hp / 2) sda_m = 1'b0;
    #(hp / 2) scl_m = 1'b1;
    #hp sda_m = 1'b1;
    #hp;
  endtask : stop
  // msb first, then the ninth bit in either direction
  task automatic byte_io(input logic [7:0] tx, input logic ak,
      output logic [7:0] rx, output logic got);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ak, got);
  endtask : byte_io
endmodule : prsr_i2c_mst
`default_nettype wire

/* test/tb_prsr_readout.sv */
`timescale 1ns/100ps
`default_nettype none
// ***************************
// readout bench
// ***************************
module tb_prsr_readout;
  import prsr_pkg::*;
  localparam int CMD_CYC = 400;
  localparam int MEAS_CYC = 1500;
  localparam logic [6:0] TGT = 7'h18;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sensor_reset_n = 1'b1;
  logic meas_done = 1'b0;
  logic [23:0] meas_pressure = 24'h000000;
  logic meas_sat = 1'b0;
  logic memerr = 1'b0;
  logic sda_oe, sda_o, scl_oe, eoc, cmd_ready, meas_start, scl_m, sda_m;
  logic [7:0] status;
  logic mem, sat;
  logic [31:0] lfsr_q = 32'h00014b80;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int num_checks = 0;
  int starts = 0;
  // open-drain lines with pull-ups
  wire sda_line = sda_m & ~(sda_oe & ~sda_o);
  wire scl_line = scl_m & ~scl_oe;
  always #2 ref_clk = ~ref_clk;
  // count start pulses mid-cycle, away from the edge that launches them
  always @(negedge ref_clk) if (meas_start === 1'b1) starts++;
  prsr_readout #(.CMD_READY_CYC(CMD_CYC), .MEAS_READY_CYC(MEAS_CYC))
  u_prsr_readout (.ref_clk, .rst, .sensor_reset_n, .scl_i(scl_line),
    .sda_i(sda_line), .sda_oe, .sda_o, .scl_oe, .eoc, .cmd_ready,
    .meas_start, .meas_done, .meas_pressure, .meas_sat, .memerr, .status);
  prsr_i2c_mst u_prsr_i2c_mst (.scl_m, .sda_m, .sda_line);
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  function automatic logic [7:0] st_exp(input logic busy);
    return {2'b01, busy, 2'b00, mem, 1'b0, sat};
  endfunction : st_exp
  task automatic cmp_byte(input string n, input logic [7:0] e,
      input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_byte
  task automatic cmp_flag(input string n, input logic e, input logic g);
    cmp_byte(n, {7'h00, e}, {7'h00, g});
  endtask : cmp_flag
  task automatic stop_test();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  // read with the address given, then every queued byte
  task automatic bus_read(input logic [6:0] a, input logic nak);
    logic [7:0] rx;
    logic ak;
    u_prsr_i2c_mst.start();
    u_prsr_i2c_mst.byte_io({a, 1'b1}, 1'b1, rx, ak);
    cmp_flag("read addr ack", nak, ak);
    while (exp_q.size() > 0) begin
      u_prsr_i2c_mst.byte_io(8'hff, exp_q.size() == 1, rx, ak);
      cmp_byte("read byte", exp_q[0], rx);
      void'(exp_q.pop_front());
    end
    u_prsr_i2c_mst.stop();
  endtask : bus_read
  // measurement command; an x ack is not compared
  task automatic bus_cmd(input logic nak);
    logic [7:0] rx;
    logic ak;
    u_prsr_i2c_mst.start();
    u_prsr_i2c_mst.byte_io({TGT, 1'b0}, 1'b1, rx, ak);
    if (nak !== 1'bx) cmp_flag("cmd addr ack", nak, ak);
    if (ak === 1'b0) begin
      u_prsr_i2c_mst.byte_io(8'haa, 1'b1, rx, ak);
      u_prsr_i2c_mst.byte_io(8'h00, 1'b1, rx, ak);
      u_prsr_i2c_mst.byte_io(8'h00, 1'b1, rx, ak);
    end
    u_prsr_i2c_mst.stop();
  endtask : bus_cmd
  // bounded wait for the command window, then the measurement delay
  task automatic wait_ready();
    for (int n = 0; n < 2 * CMD_CYC && cmd_ready !== 1'b1; n++) begin
      @(negedge ref_clk);
    end
    cmp_flag("cmd ready", 1'b1, cmd_ready);
    repeat (MEAS_CYC) @(negedge ref_clk);
  endtask : wait_ready
  // watchdog: several times the expected run of about 12800 cycles
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
  // main sequence
  initial begin
    mem = 1'b0;
    sat = 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    bus_cmd(1'b1);
    exp_q.push_back(st_exp(1'b1));
    bus_read(TGT, 1'b0);
    wait_ready();
    exp_q.push_back(st_exp(1'b0));
    bus_read(TGT, 1'b0);
    bus_read(7'h28, 1'b1);
    cmp_flag("eoc before result", 1'b0, eoc);
    cmp_flag("data released", 1'b0, sda_oe);
    cmp_byte("status port", st_exp(1'b0), status);
    for (int k = 0; k < 3; k++) begin
      u_prsr_i2c_mst.hp = (k == 1) ? 96 : 32;
      bus_cmd(1'b0);
      if (k == 0) bus_cmd(1'bx);
      repeat (4) @(negedge ref_clk);
      cmp_byte("starts", 8'(k + 1), 8'(starts));
      cmp_flag("eoc idle", 1'b0, eoc);
      lfsr_q = lfsr_next(lfsr_q);
      meas_pressure = lfsr_q[23:0];
      meas_sat = lfsr_q[31];
      meas_done = 1'b1;
      @(negedge ref_clk);
      meas_done = 1'b0;
      sat = meas_sat;
      repeat (2) @(negedge ref_clk);
      cmp_flag("eoc", 1'b1, eoc);
      exp_q = {st_exp(1'b0), meas_pressure[23:16], meas_pressure[15:8],
        meas_pressure[7:0]};
      // last pass reads past the queue: ones follow the fourth byte
      if (k == 2) begin
        exp_q.push_back(8'hff);
        exp_q.push_back(8'hff);
      end
      bus_read(TGT, 1'b0);
    end
    memerr = 1'b1;
    sensor_reset_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    cmp_byte("status in reset", 8'h00, status);
    cmp_flag("ready in reset", 1'b0, cmd_ready);
    sensor_reset_n = 1'b1;
    mem = 1'b1;
    sat = 1'b0;
    bus_cmd(1'b1);
    exp_q.push_back(st_exp(1'b1));
    bus_read(TGT, 1'b0);
    wait_ready();
    exp_q.push_back(st_exp(1'b0));
    bus_read(TGT, 1'b0);
    stop_test();
  end
endmodule : tb_prsr_readout
`default_nettype wire
